// file: usbwk_consts.svh
`ifndef USBWK_CONSTS_SVH
`define USBWK_CONSTS_SVH

// ------------------------------------------------
// register offsets
// ------------------------------------------------
`define USBWK_OFS_CTL 16'hF001
`define USBWK_OFS_MSK 16'hF002
`define USBWK_OFS_STA 16'hF003
`define USBWK_OFS_FUNCTION_ADDRESS_REG 16'hF009
`define USBWK_OFS_WKUP 16'hF00D
`define USBWK_OFS_MCUCFG 16'hF010

// ------------------------------------------------
// field positions and reset values
// ------------------------------------------------
`define USBWK_CTL_LOW_POWER_ENABLE 6
`define USBWK_CTL_REMOTE_WAKEUP_ENABLE 5
`define USBWK_MSK_WAKE 2
`define USBWK_STA_WAKE 0
`define USBWK_CFG_EN_LO 2
`define USBWK_CFG_EN_HI 5
`define USBWK_FA_HS 7
`define USBWK_NSRC 5
`define USBWK_RST8 8'h00
`define USBWK_RST5 5'h00

// ------------------------------------------------
// timing
// ------------------------------------------------
`define USBWK_CLK_MHZ 50
`define USBWK_RESUME_MS 10

`endif

// file: usbwk_pkg.sv
package usbwk_pkg;
	// wake sequencer states
	typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAIT} usbwk_state_t;
endpackage

// file: usbwk_evt_if.sv
`include "usbwk_consts.svh"

interface usbwk_evt_if;
	logic [`USBWK_NSRC-1:0] pins; // raw source levels
	logic [`USBWK_NSRC-1:0] change; // one-cycle change pulses
	modport det (input pins, output change);
	modport core (output pins, input change);
endinterface

// file: usbwk_change_det.sv
`include "usbwk_consts.svh"

module usbwk_change_det (
	input wire logic mclk_i, // core clock
	input wire logic rst_i, // synchronous reset
	usbwk_evt_if.det evt // pins in, change pulses out
);
	// ------------------------------------------------
	// per-source three-flop sync and change detect
	// ------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `USBWK_NSRC; g++)
		begin : g_src
			logic s1_ff, s2_ff, s3_ff, stab_ff, pls_ff;
			logic nxt_stab, nxt_pls;
			// change counts once 2nd and 3rd stages agree
			always_comb
			begin
				nxt_stab = stab_ff;
				nxt_pls = 1'b0;
				if (s2_ff == s3_ff && s3_ff != stab_ff)
				begin
					nxt_stab = s3_ff;
					nxt_pls = 1'b1;
				end
			end
			// metastability chain before any use
			always_ff @(posedge mclk_i)
			begin
				if (rst_i)
				begin
					s1_ff <= 1'b0;
					s2_ff <= 1'b0;
					s3_ff <= 1'b0;
					stab_ff <= 1'b0;
					pls_ff <= 1'b0;
				end
				else
				begin
					s1_ff <= evt.pins[g];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					stab_ff <= nxt_stab;
					pls_ff <= nxt_pls;
				end
			end
			assign evt.change[g] = pls_ff;
		end
	endgenerate
endmodule

// file: usbwk_top.sv
// Functional notes
// - wake irq also usable outside suspend
// - suspended wake event with remote wakeup enabled restarts clock, irq, resume
// - resume at earlier of clear or 10ms
// - vbus change always enabled, no enable bit
// - no-lowpower suspend: event raises irq immediately
// - lowpower no-remote suspend: event latched silently
// - latched event raises irq when clock returns
// - control bit 6 stops clock in suspend
// - mask bit 2 gates irq and clock wake
// - control bit 5 gates clock wake, resume
// - config bits 2..5 enable four pin sources
// - function address bits 6..0 read zero after resets
// - any reset clears function address
// - address bit 7 is read-only speed flag
// - source pulses ORed, set status if clear
// - write-one clears shared status, keeps reasons
// - reason bits sticky until written one
`include "usbwk_consts.svh"

module usbwk_top #(
	parameter int RESUME_CYC = `USBWK_RESUME_MS * 1000 * `USBWK_CLK_MHZ * 1000 / 1000
) (
	input wire logic mclk_i, // core clock 50 MHz
	input wire logic rst_i, // power-up reset
	input wire logic wdt_rst_i, // watchdog reset
	input wire logic usb_rst_i, // usb bus reset
	input wire logic [15:0] xaddr_i, // register address
	input wire logic xwr_i, // register write strobe
	input wire logic xrd_i, // register read strobe
	input wire logic [7:0] xwdata_i, // write data
	output logic [7:0] xrdata_o, // registered read data
	input wire logic vbus_i, // vbus pin level
	input wire logic [3:0] p3_pin_i, // p3.4 p3.5 p3.2 p3.3
	input wire logic suspend_i, // usb suspend state
	input wire logic host_resume_i, // host signals resume
	input wire logic high_speed_i, // transceiver speed select
	output logic wake_event_irq_o, // wake irq to mcu
	output logic clk_stop_o, // core clock shutdown request
	output logic resume_start_o // start upstream resume
);
	localparam int CW = 20;

	// ------------------------------------------------
	// event detection
	// ------------------------------------------------
	usbwk_evt_if evt ();
	assign evt.pins = {p3_pin_i, vbus_i};

	usbwk_change_det u_det (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.evt(evt)
	);

	// ------------------------------------------------
	// register state
	// ------------------------------------------------
	// registered state
	logic [7:0] ctl_ff; // usb control register
	logic [7:0] msk_ff; // usb irq mask register
	logic [7:0] cfg_ff; // mcu config register
	logic [7:0] rdata_ff; // read data holding register
	logic [6:0] fa_ff; // device address field
	logic [`USBWK_NSRC-1:0] wkup_ff; // wake reason bits
	logic sta_ff; // shared wake status bit
	logic pend_ff; // event latched with clock stopped
	logic resume_ff; // resume start pulse
	// next values
	logic [7:0] nxt_ctl; // next control
	logic [7:0] nxt_msk; // next mask
	logic [7:0] nxt_cfg; // next config
	logic [7:0] nxt_rdata; // next read data
	logic [6:0] nxt_fa; // next address
	logic [`USBWK_NSRC-1:0] nxt_wkup; // next reasons
	logic nxt_sta; // next status
	logic nxt_pend; // next latched event
	logic nxt_resume; // next resume pulse
	usbwk_pkg::usbwk_state_t st_ff; // wake sequencer state
	usbwk_pkg::usbwk_state_t nxt_st; // next sequencer state
	logic [CW-1:0] cnt_ff; // resume timeout counter
	logic [CW-1:0] nxt_cnt; // next counter value

	// decoded controls
	logic low_power_enable; // clock shutdown in suspend
	logic remote_wakeup_enable; // remote wakeup allowed
	logic wake_en; // wake irq enabled
	logic any_det; // any enabled source changed
	logic sta_clr; // firmware clears wake status
	logic timeout; // resume delay elapsed
	logic [`USBWK_NSRC-1:0] src_en; // per-source enables
	logic [`USBWK_NSRC-1:0] det; // enabled change pulses

	// decoded enables and events
	assign low_power_enable = ctl_ff[`USBWK_CTL_LOW_POWER_ENABLE];
	assign remote_wakeup_enable = ctl_ff[`USBWK_CTL_REMOTE_WAKEUP_ENABLE];
	assign wake_en = msk_ff[`USBWK_MSK_WAKE];
	assign src_en = {cfg_ff[`USBWK_CFG_EN_HI:`USBWK_CFG_EN_LO], 1'b1};
	assign det = evt.change & src_en;
	assign any_det = |det;
	assign sta_clr = xwr_i && xaddr_i == `USBWK_OFS_STA && xwdata_i[`USBWK_STA_WAKE];
	assign timeout = cnt_ff == CW'(RESUME_CYC - 1);

	// ------------------------------------------------
	// register file and wake logic next values
	// ------------------------------------------------
	always_comb
	begin
		nxt_ctl = ctl_ff;
		nxt_msk = msk_ff;
		nxt_cfg = cfg_ff;
		nxt_fa = fa_ff;
		nxt_rdata = rdata_ff;
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_resume = 1'b0;
		nxt_pend = pend_ff;
		nxt_wkup = wkup_ff;
		nxt_sta = sta_ff;
		// writes
		if (xwr_i)
		begin
			unique case (xaddr_i)
				`USBWK_OFS_CTL: nxt_ctl = xwdata_i;
				`USBWK_OFS_MSK: nxt_msk = xwdata_i;
				`USBWK_OFS_MCUCFG: nxt_cfg = xwdata_i;
				`USBWK_OFS_FUNCTION_ADDRESS_REG: nxt_fa = xwdata_i[6:0];
				`USBWK_OFS_WKUP: nxt_wkup = wkup_ff & ~xwdata_i[`USBWK_NSRC-1:0];
				default: ;
			endcase
		end
		if (sta_clr)
			nxt_sta = 1'b0;
		// reason bits: set wins over clear
		nxt_wkup = nxt_wkup | det;
		// sequencer
		unique case (st_ff)
			// run: irq on new or latched event
			usbwk_pkg::ST_RUN:
			begin
				if (suspend_i && low_power_enable && !(remote_wakeup_enable && wake_en && any_det))
					nxt_st = usbwk_pkg::ST_SLEEP;
				else if (suspend_i && remote_wakeup_enable && wake_en && any_det)
					nxt_st = usbwk_pkg::ST_WAIT;
				if (wake_en && !sta_ff && (any_det || pend_ff))
				begin
					nxt_sta = 1'b1;
					nxt_pend = 1'b0;
				end
			end
			// sleep: clock stopped, events latched, remote wake goes to wait
			usbwk_pkg::ST_SLEEP:
			begin
				if (any_det)
					nxt_pend = 1'b1;
				if (remote_wakeup_enable && wake_en && (any_det || pend_ff))
					nxt_st = usbwk_pkg::ST_WAIT;
				else if (host_resume_i || !suspend_i)
					nxt_st = usbwk_pkg::ST_RUN;
			end
			// wait: irq up, count towards resume
			usbwk_pkg::ST_WAIT:
			begin
				if (wake_en && !sta_ff && (any_det || pend_ff))
				begin
					nxt_sta = 1'b1;
					nxt_pend = 1'b0;
				end
				if (sta_ff)
					nxt_cnt = cnt_ff + CW'(1);
				if (sta_ff && (sta_clr || timeout))
				begin
					nxt_resume = 1'b1;
					nxt_cnt = '0;
					nxt_st = usbwk_pkg::ST_RUN;
				end
				else if (!suspend_i)
				begin
					nxt_cnt = '0;
					nxt_st = usbwk_pkg::ST_RUN;
				end
			end
			default: nxt_st = usbwk_pkg::ST_RUN;
		endcase
		// registered read data
		if (xrd_i)
		begin
			unique case (xaddr_i)
				`USBWK_OFS_CTL: nxt_rdata = ctl_ff;
				`USBWK_OFS_MSK: nxt_rdata = msk_ff;
				`USBWK_OFS_MCUCFG: nxt_rdata = cfg_ff;
				`USBWK_OFS_STA: nxt_rdata = 8'(sta_ff) << `USBWK_STA_WAKE;
				`USBWK_OFS_WKUP: nxt_rdata = {3'h0, wkup_ff};
				`USBWK_OFS_FUNCTION_ADDRESS_REG: nxt_rdata = {high_speed_i, fa_ff};
				default: nxt_rdata = `USBWK_RST8;
			endcase
		end
	end

	// ------------------------------------------------
	// state registers
	// ------------------------------------------------
	always_ff @(posedge mclk_i)
	begin
		if (rst_i || wdt_rst_i)
		begin
			ctl_ff <= `USBWK_RST8;
			msk_ff <= `USBWK_RST8;
			cfg_ff <= `USBWK_RST8;
			rdata_ff <= `USBWK_RST8;
			wkup_ff <= `USBWK_RST5;
			sta_ff <= 1'b0;
			pend_ff <= 1'b0;
			resume_ff <= 1'b0;
			st_ff <= usbwk_pkg::ST_RUN;
			cnt_ff <= '0;
		end
		else
		begin
			ctl_ff <= nxt_ctl;
			msk_ff <= nxt_msk;
			cfg_ff <= nxt_cfg;
			rdata_ff <= nxt_rdata;
			wkup_ff <= nxt_wkup;
			sta_ff <= nxt_sta;
			pend_ff <= nxt_pend;
			resume_ff <= nxt_resume;
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
		end
	end

	// function address cleared by every reset kind
	always_ff @(posedge mclk_i)
	begin
		if (rst_i || wdt_rst_i || usb_rst_i)
			fa_ff <= 7'h00;
		else
			fa_ff <= nxt_fa;
	end

	// outputs
	assign xrdata_o = rdata_ff;
	assign wake_event_irq_o = sta_ff;
	assign clk_stop_o = st_ff == usbwk_pkg::ST_SLEEP;
	assign resume_start_o = resume_ff;

	// ------------------------------------------------
	// assertions
	// ------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i || wdt_rst_i);

	irq_sets_event_a: assert property (
		st_ff != usbwk_pkg::ST_SLEEP && wake_en && !sta_ff && any_det |=> sta_ff)
		else $error("wake status not set by event");
	irq_gated_mask_a: assert property (
		!sta_ff && !wake_en |=> !sta_ff)
		else $error("wake status set while masked");
	sleep_no_irq_a: assert property (
		st_ff == usbwk_pkg::ST_SLEEP && !sta_ff |=> !sta_ff)
		else $error("irq raised with clock stopped");
	clear_keeps_reason_a: assert property (
		sta_clr && !any_det |=> !sta_ff && wkup_ff == $past(wkup_ff))
		else $error("status clear disturbed reasons");
	reason_sticky_a: assert property (
		!(xwr_i && xaddr_i == `USBWK_OFS_WKUP) |=> (wkup_ff & $past(wkup_ff)) == $past(wkup_ff))
		else $error("reason bit lost");
	vbus_always_a: assert property (
		evt.change[0] |=> wkup_ff[0])
		else $error("vbus change not recorded");
	resume_on_clear_a: assert property (
		st_ff == usbwk_pkg::ST_WAIT && sta_ff && sta_clr |=> resume_start_o)
		else $error("no resume after clear");
	resume_needs_rwup_a: assert property (
		st_ff == usbwk_pkg::ST_RUN && !remote_wakeup_enable |=> !(st_ff == usbwk_pkg::ST_WAIT))
		else $error("wait entered without remote wakeup");
	pend_fires_a: assert property (
		st_ff == usbwk_pkg::ST_RUN && pend_ff && wake_en && !sta_ff |=> sta_ff && !pend_ff)
		else $error("latched event not raised");
	lp_stops_clk_a: assert property (
		st_ff == usbwk_pkg::ST_RUN && suspend_i && low_power_enable && !any_det |=> clk_stop_o)
		else $error("clock not stopped in suspend");

	// resume timeout, address and source enables
	resume_timeout_a: assert property (
		st_ff == usbwk_pkg::ST_WAIT && sta_ff && timeout |=> resume_start_o)
		else $error("no resume after timeout");
	fa_usb_clear_a: assert property (
		usb_rst_i |=> fa_ff == '0)
		else $error("address kept over usb reset");
	hs_read_a: assert property (
		xrd_i && xaddr_i == `USBWK_OFS_FUNCTION_ADDRESS_REG
		|=> xrdata_o[`USBWK_FA_HS] == $past(high_speed_i))
		else $error("speed flag not read back");
	src_masked_a: assert property (
		evt.change != '0
		|=> (wkup_ff & ~$past(wkup_ff) & ~$past(src_en)) == '0)
		else $error("disabled source recorded");

	// main scenarios
	remote_wake_c: cover property (st_ff == usbwk_pkg::ST_WAIT ##[1:20] resume_start_o);
	latched_wake_c: cover property (pend_ff && st_ff == usbwk_pkg::ST_SLEEP ##[1:50] sta_ff);
	normal_irq_c: cover property (!suspend_i && any_det ##1 sta_ff);
	early_resume_c: cover property (sta_clr && st_ff == usbwk_pkg::ST_WAIT ##1 resume_start_o);
	masked_src_c: cover property (evt.change != '0 && !any_det);
endmodule

// file: usbwk_host_model.sv
module usbwk_host_model (
	input wire logic clk_i, // core clock
	output logic vbus_o, // vbus level
	output logic [3:0] pin_o, // port3 pin levels
	output logic susp_o, // bus suspend state
	output logic res_o // host resume seen
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle levels at time zero
	initial
	begin
		vbus_o = 1'b0;
		pin_o = 4'h0;
		susp_o = 1'b0;
		res_o = 1'b0;
	end
	// change one source level, index 4 is vbus
	task automatic flip(input int i);
		@(posedge clk_i);
		#1;
		if (i == 4)
			vbus_o = ~vbus_o;
		else
			pin_o[i] = ~pin_o[i];
	endtask
	// enter or leave suspend
	task automatic susp(input logic v);
		@(posedge clk_i);
		#1;
		susp_o = v;
	endtask
	// host resume brings the clock back and ends suspend
	task automatic resume();
		@(posedge clk_i);
		#1;
		res_o = 1'b1;
		susp_o = 1'b0;
		@(posedge clk_i);
		#1;
		res_o = 1'b0;
	endtask
endmodule

// file: tb_top.sv
`include "usbwk_consts.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RC = 50;
	logic mclk_i, rst_i, wdt_rst_i, usb_rst_i, xwr_i, xrd_i, high_speed_i, vbus_i;
	logic suspend_i, host_resume_i, wake_event_irq_o, clk_stop_o, resume_start_o;
	logic [15:0] xaddr_i;
	logic [7:0] xwdata_i, xrdata_o;
	logic [3:0] p3_pin_i;
	int n_fail = 0;
	int cmp_count = 0;
	int n;
	usbwk_top #(.RESUME_CYC(RC)) u_usbwk_top (.mclk_i(mclk_i), .rst_i(rst_i),
		.wdt_rst_i(wdt_rst_i), .usb_rst_i(usb_rst_i), .xaddr_i(xaddr_i), .xwr_i(xwr_i),
		.xrd_i(xrd_i), .xwdata_i(xwdata_i), .xrdata_o(xrdata_o), .vbus_i(vbus_i),
		.p3_pin_i(p3_pin_i), .suspend_i(suspend_i), .host_resume_i(host_resume_i),
		.high_speed_i(high_speed_i), .wake_event_irq_o(wake_event_irq_o),
		.clk_stop_o(clk_stop_o), .resume_start_o(resume_start_o));
	usbwk_host_model u_usbwk_host_model (.clk_i(mclk_i), .vbus_o(vbus_i), .pin_o(p3_pin_i),
		.susp_o(suspend_i), .res_o(host_resume_i));
	// verdict and end of run
	task automatic complete_run();
		if (n_fail == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// compare and count
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// advance k edges, drive just after the edge
	task automatic step(input int k);
		repeat (k) @(posedge mclk_i);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		xaddr_i = a;
		xwdata_i = d;
		xwr_i = 1'b1;
		step(1);
		xwr_i = 1'b0;
		step(1);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e, input string nm);
		xaddr_i = a;
		xrd_i = 1'b1;
		step(1);
		xrd_i = 1'b0;
		chk(nm, xrdata_o, e);
		step(1);
	endtask
	// bounded wait for the irq level
	task automatic wait_irq(input logic v);
		for (int i = 0; i < 200; i++)
		begin
			if (wake_event_irq_o === v)
			begin
				chk("irq", {7'h00, wake_event_irq_o}, {7'h00, v});
				return;
			end
			step(1);
		end
		n_fail++;
		complete_run();
	endtask
	// bounded wait for the resume pulse, k counts cycles
	task automatic wait_res(output int k);
		k = 0;
		while (resume_start_o !== 1'b1 && k < 300)
		begin
			step(1);
			k++;
		end
		if (k >= 300)
		begin
			n_fail++;
			complete_run();
		end
	endtask
	// clear shared status then reasons
	task automatic clr();
		wr(`USBWK_OFS_STA, 8'h01);
		wr(`USBWK_OFS_WKUP, 8'h1F);
	endtask
	initial
	begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	// main sequence
	initial
	begin
		rst_i = 1'b1;
		wdt_rst_i = 1'b0;
		usb_rst_i = 1'b0;
		xwr_i = 1'b0;
		xrd_i = 1'b0;
		high_speed_i = 1'b0;
		xaddr_i = 16'h0000;
		xwdata_i = 8'h00;
		step(10);
		rst_i = 1'b0;
		rd(`USBWK_OFS_FUNCTION_ADDRESS_REG, 8'h00, "fa_rst");
		wr(`USBWK_OFS_FUNCTION_ADDRESS_REG, 8'hFF);
		rd(`USBWK_OFS_FUNCTION_ADDRESS_REG, 8'h7F, "fa_wr");
		high_speed_i = 1'b1;
		rd(`USBWK_OFS_FUNCTION_ADDRESS_REG, 8'hFF, "fa_hs");
		usb_rst_i = 1'b1;
		step(1);
		usb_rst_i = 1'b0;
		rd(`USBWK_OFS_FUNCTION_ADDRESS_REG, 8'h80, "fa_usb");
		wr(`USBWK_OFS_FUNCTION_ADDRESS_REG, 8'h2A);
		wdt_rst_i = 1'b1;
		step(1);
		wdt_rst_i = 1'b0;
		rd(`USBWK_OFS_FUNCTION_ADDRESS_REG, 8'h80, "fa_wdt");
		rd(16'hF0FF, 8'h00, "unmapped");
		wr(`USBWK_OFS_MSK, 8'h04);
		wr(`USBWK_OFS_MCUCFG, 8'h3C);
		rd(`USBWK_OFS_MSK, 8'h04, "msk");
		rd(`USBWK_OFS_MCUCFG, 8'h3C, "cfg");
		u_usbwk_host_model.flip(0);
		wait_irq(1'b1);
		u_usbwk_host_model.flip(2);
		step(8);
		rd(`USBWK_OFS_STA, 8'h01, "sta");
		rd(`USBWK_OFS_WKUP, 8'h0A, "why");
		wr(`USBWK_OFS_STA, 8'h01);
		wait_irq(1'b0);
		rd(`USBWK_OFS_WKUP, 8'h0A, "why_kept");
		wr(`USBWK_OFS_WKUP, 8'h1F);
		rd(`USBWK_OFS_WKUP, 8'h00, "why_clr");
		wr(`USBWK_OFS_MCUCFG, 8'h00);
		u_usbwk_host_model.flip(1);
		step(10);
		rd(`USBWK_OFS_WKUP, 8'h00, "src_off");
		u_usbwk_host_model.flip(4);
		wait_irq(1'b1);
		rd(`USBWK_OFS_WKUP, 8'h01, "vbus");
		clr();
		wr(`USBWK_OFS_MSK, 8'h00);
		wr(`USBWK_OFS_MCUCFG, 8'h3C);
		u_usbwk_host_model.flip(3);
		step(10);
		chk("masked", {7'h00, wake_event_irq_o}, 8'h00);
		wr(`USBWK_OFS_WKUP, 8'h1F);
		wr(`USBWK_OFS_MSK, 8'h04);
		u_usbwk_host_model.susp(1'b1);
		u_usbwk_host_model.flip(0);
		wait_irq(1'b1);
		chk("run_clk", {7'h00, clk_stop_o}, 8'h00);
		clr();
		u_usbwk_host_model.susp(1'b0);
		wr(`USBWK_OFS_CTL, 8'h60);
		rd(`USBWK_OFS_CTL, 8'h60, "ctl");
		u_usbwk_host_model.susp(1'b1);
		step(4);
		chk("stop_clk", {7'h00, clk_stop_o}, 8'h01);
		u_usbwk_host_model.flip(4);
		wait_irq(1'b1);
		wait_res(n);
		chk("res_late", 8'((n >= RC - 3) && (n <= RC + 3)), 8'h01);
		u_usbwk_host_model.susp(1'b0);
		clr();
		u_usbwk_host_model.susp(1'b1);
		step(4);
		u_usbwk_host_model.flip(0);
		wait_irq(1'b1);
		xaddr_i = `USBWK_OFS_STA;
		xwdata_i = 8'h01;
		xwr_i = 1'b1;
		step(1);
		xwr_i = 1'b0;
		wait_res(n);
		chk("res_early", 8'(n <= 4), 8'h01);
		u_usbwk_host_model.susp(1'b0);
		clr();
		wr(`USBWK_OFS_CTL, 8'h40);
		u_usbwk_host_model.susp(1'b1);
		step(4);
		u_usbwk_host_model.flip(1);
		step(20);
		chk("latched", {6'h00, wake_event_irq_o, resume_start_o}, 8'h00);
		chk("still_stop", {7'h00, clk_stop_o}, 8'h01);
		u_usbwk_host_model.resume();
		wait_irq(1'b1);
		complete_run();
	end
endmodule
